// ---- rcc_pkg.sv ----
// package of constants and types for the reader cycle control block
`default_nettype none
package rcc_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD;
  localparam int unsigned TRIG_PULSE_US = 100;
  localparam int unsigned TRIG_PULSE_CYC = (TRIG_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BURST_MS = 50;
  localparam int unsigned BURST_CYC = BURST_MS * (CLK_HZ / 1000);
  localparam int unsigned VALID_MS = 60;
  localparam int unsigned VALID_CYC = VALID_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_MIN_MS = 1;
  localparam int unsigned RESET_MIN_CYC = RESET_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 24;
  // ==========================================================
  // serial framing
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] XOFF_BYTE = 8'h13;
  localparam logic [7:0] XON_BYTE = 8'h11;
  // ==========================================================
  // command byte layout
  localparam int unsigned CMD_SYNC_BIT = 1;
  localparam int unsigned CMD_SYNC_VALID_BIT = 7;
  // ==========================================================
  // interrupt status bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_CYCLE_DONE = 0;
  localparam int unsigned EV_VALID_READ = 1;
  localparam int unsigned EV_RX_BYTE = 2;
  localparam int unsigned EV_RX_ERR = 3;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_TX_DATA = 8'h0C;
  localparam logic [7:0] REG_RX_DATA = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam int unsigned RES_DONE_BIT = 0;
  localparam int unsigned RES_VALID_BIT = 1;
  typedef enum logic [2:0] {
    RCC_IDLE,
    RCC_HOLD,
    RCC_TRIG,
    RCC_BURST,
    RCC_RESULT
  } rcc_state_t;
endpackage : rcc_pkg
`default_nettype wire

// ---- rcc_uart_if.sv ----
// interface between cycle control and its serial engine
`default_nettype none
interface rcc_uart_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  modport ctrl (output tx_data, output tx_valid, input tx_ready, input rx_data, input rx_valid, input rx_err);
  modport uart (input tx_data, input tx_valid, output tx_ready, output rx_data, output rx_valid, output rx_err);
endinterface : rcc_uart_if
`default_nettype wire

// ---- rcc_uart.sv ----
// 9600 baud 8n1 serial transmitter and receiver
`default_nettype none
module rcc_uart (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rxd,
  output logic txd,
  rcc_uart_if.uart u
);
  localparam int unsigned DIV = rcc_pkg::BAUD_DIV;
  localparam logic [15:0] DIV_M1 = 16'(DIV - 1);
  localparam logic [15:0] HALF = 16'(DIV / 2);

  // ==========================================================
  // transmitter
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [3:0] tbit_r, tbit_nxt;
  logic [9:0] tsh_r, tsh_nxt;
  logic tbusy_r, tbusy_nxt;
  logic txd_r, txd_nxt;

  assign u.tx_ready = !tbusy_r;
  assign txd = txd_r;

  always_comb begin
    tcnt_nxt = tcnt_r;
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    tbusy_nxt = tbusy_r;
    txd_nxt = txd_r;
    if (!tbusy_r) begin
      txd_nxt = 1'b1;
      if (u.tx_valid) begin
        tsh_nxt = {1'b1, u.tx_data, 1'b0};
        tbusy_nxt = 1'b1;
        tcnt_nxt = '0;
        tbit_nxt = '0;
        txd_nxt = 1'b0;
      end
    end else if (tcnt_r == DIV_M1) begin
      tcnt_nxt = '0;
      if (tbit_r == 4'd9) begin
        tbusy_nxt = 1'b0;
        txd_nxt = 1'b1;
      end else begin
        tbit_nxt = tbit_r + 4'd1;
        txd_nxt = tsh_r[tbit_r + 4'd1];
      end
    end else begin
      tcnt_nxt = tcnt_r + 16'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_r <= '0;
      tbit_r <= '0;
      tsh_r <= '1;
      tbusy_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      tcnt_r <= tcnt_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      tbusy_r <= tbusy_nxt;
      txd_r <= txd_nxt;
    end
  end

  // ==========================================================
  // receiver, sampled mid bit
  logic [15:0] rcnt_r, rcnt_nxt;
  logic [3:0] rbit_r, rbit_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic rbusy_r, rbusy_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic rvld_r, rvld_nxt;
  logic rerr_r, rerr_nxt;

  assign u.rx_data = rdat_r;
  assign u.rx_valid = rvld_r;
  assign u.rx_err = rerr_r;

  always_comb begin
    rcnt_nxt = rcnt_r;
    rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;
    rbusy_nxt = rbusy_r;
    rdat_nxt = rdat_r;
    rvld_nxt = 1'b0;
    rerr_nxt = 1'b0;
    if (!rbusy_r) begin
      if (!rxd) begin
        rbusy_nxt = 1'b1;
        rcnt_nxt = '0;
        rbit_nxt = '0;
      end
    end else if ((rbit_r == 4'd0 && rcnt_r == HALF) || (rbit_r != 4'd0 && rcnt_r == DIV_M1)) begin
      rcnt_nxt = '0;
      rbit_nxt = rbit_r + 4'd1;
      if (rbit_r == 4'd0) begin
        // glitch on the start bit: drop back to hunting
        if (rxd) begin
          rbusy_nxt = 1'b0;
        end
      end else if (rbit_r == 4'd9) begin
        rbusy_nxt = 1'b0;
        if (rxd) begin
          rdat_nxt = rsh_r;
          rvld_nxt = 1'b1;
        end else begin
          rerr_nxt = 1'b1;
        end
      end else begin
        rsh_nxt = {rxd, rsh_r[7:1]};
      end
    end else begin
      rcnt_nxt = rcnt_r + 16'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_r <= '0;
      rbit_r <= '0;
      rsh_r <= '0;
      rbusy_r <= 1'b0;
      rdat_r <= '0;
      rvld_r <= 1'b0;
      rerr_r <= 1'b0;
    end else begin
      rcnt_r <= rcnt_nxt;
      rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;
      rbusy_r <= rbusy_nxt;
      rdat_r <= rdat_nxt;
      rvld_r <= rvld_nxt;
      rerr_r <= rerr_nxt;
    end
  end
endmodule : rcc_uart
`default_nettype wire

// ---- rcc_top.sv ----
// reader cycle control: read cycle sequencing, pin outputs, serial and registers
// Functional notes
// - sync output high from read cycle start until cycle fully done, else low
// - while hold-off input high, transmitter stays off; start only after it falls
// - hold-off sampled only at cycle start; later rise does not abort cycle
// - 100 us high pulse on hold-off while idle starts one read at its fall
// - reset held while reset low; host holds it low at least 1 ms
// - serial receive bytes are 8n1 at 9600 baud
// - serial transmit bytes are 8n1 at 9600 baud
// - continuous input high runs repeated charge-only reads without commands
// - continuous input low idles until command or trigger pulse
// - wireless-align input high enables wireless sync, low disables it
// - wireless sync enabled tries to align bursts with nearby readers; here it only drives wireless_align_active, burst timing ignores it
// - command sync setting overrides wireless-align input only during that command
// - valid read raises valid flag output for about 60 ms
// - transmitter status output low while transmitter active, high otherwise
// - trigger and continuous reads use a 50 ms power burst
// - serial command runs even in continuous mode, then previous mode resumes
// - command during hold-off waits for its fall; only newest command kept
`default_nettype none
module rcc_top #(
  parameter int unsigned BURST_CYC = rcc_pkg::BURST_CYC,
  parameter int unsigned VALID_CYC = rcc_pkg::VALID_CYC,
  parameter int unsigned TRIG_CYC = rcc_pkg::TRIG_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic holdoff_trigger_in,
  input wire logic continuous_read_in,
  input wire logic wireless_align_in,
  input wire logic rxd,
  output logic txd,
  output logic sync_out,
  output logic tx_status_n,
  output logic valid_read_flag_out,
  output logic rf_enable,
  output logic wireless_align_active,
  input wire logic tag_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  localparam logic [rcc_pkg::CNT_W-1:0] BURST_M1 = rcc_pkg::CNT_W'(BURST_CYC - 1);
  localparam logic [rcc_pkg::CNT_W-1:0] VALID_M1 = rcc_pkg::CNT_W'(VALID_CYC - 1);
  localparam logic [rcc_pkg::CNT_W-1:0] TRIG_MIN = rcc_pkg::CNT_W'(TRIG_CYC);

  // ==========================================================
  // reset release
  logic rst_s1_r, rst_n;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ==========================================================
  // serial engine
  rcc_uart_if ui ();
  rcc_uart u_uart (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rxd(rxd),
    .txd(txd),
    .u(ui.uart)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // cycle sequencer state
  rcc_pkg::rcc_state_t st_r, st_nxt;
  logic [rcc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [rcc_pkg::CNT_W-1:0] hcnt_r, hcnt_nxt;
  logic [rcc_pkg::CNT_W-1:0] vcnt_r, vcnt_nxt;
  logic hold_d_r, hold_d_nxt;
  logic vflag_r, vflag_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic cmd_pend_r, cmd_pend_nxt;
  logic cmd_act_r, cmd_act_nxt;
  logic got_valid_r, got_valid_nxt;
  logic paused_r, paused_nxt;
  logic ev_done, ev_valid;
  logic [31:0] result_r, result_nxt;
  logic hold_fall;
  logic cmd_byte;

  assign hold_fall = hold_d_r && !holdoff_trigger_in;
  assign cmd_byte = ui.rx_valid && ui.rx_data != rcc_pkg::XON_BYTE && ui.rx_data != rcc_pkg::XOFF_BYTE;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    hcnt_nxt = hcnt_r;
    vcnt_nxt = vcnt_r;
    hold_d_nxt = holdoff_trigger_in;
    vflag_nxt = vflag_r;
    cmd_nxt = cmd_r;
    cmd_pend_nxt = cmd_pend_r;
    cmd_act_nxt = cmd_act_r;
    got_valid_nxt = got_valid_r;
    paused_nxt = paused_r;
    result_nxt = result_r;
    ev_done = 1'b0;
    ev_valid = 1'b0;
    // xon/xoff handshake pauses new cycles
    if (ui.rx_valid && ui.rx_data == rcc_pkg::XOFF_BYTE) begin
      paused_nxt = 1'b1;
    end else if (ui.rx_valid && ui.rx_data == rcc_pkg::XON_BYTE) begin
      paused_nxt = 1'b0;
    end
    if (cmd_byte) begin
      cmd_nxt = ui.rx_data;
      cmd_pend_nxt = 1'b1;
    end
    // hold-off pulse width counter
    if (holdoff_trigger_in) begin
      if (hcnt_r != '1) begin
        hcnt_nxt = hcnt_r + 1'b1;
      end
    end else begin
      hcnt_nxt = '0;
    end
    unique0 case (st_r)
      rcc_pkg::RCC_IDLE: begin
        if (!paused_r) begin
          if (cmd_pend_r || cmd_byte) begin
            st_nxt = holdoff_trigger_in ? rcc_pkg::RCC_HOLD : rcc_pkg::RCC_BURST;
            cnt_nxt = '0;
            cmd_act_nxt = !holdoff_trigger_in;
            cmd_pend_nxt = holdoff_trigger_in;
          end else if (continuous_read_in) begin
            st_nxt = holdoff_trigger_in ? rcc_pkg::RCC_HOLD : rcc_pkg::RCC_BURST;
            cnt_nxt = '0;
          end else if (hold_fall && hcnt_r >= TRIG_MIN) begin
            st_nxt = rcc_pkg::RCC_BURST;
            cnt_nxt = '0;
          end
        end
      end
      rcc_pkg::RCC_HOLD: begin
        if (!holdoff_trigger_in) begin
          st_nxt = rcc_pkg::RCC_BURST;
          cnt_nxt = '0;
          // a byte landing on the same edge as the release still runs
          cmd_act_nxt = cmd_pend_r || cmd_byte;
          cmd_pend_nxt = 1'b0;
        end
      end
      rcc_pkg::RCC_BURST: begin
        got_valid_nxt = got_valid_r | tag_valid;
        if (cnt_r == BURST_M1) begin
          st_nxt = rcc_pkg::RCC_RESULT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      rcc_pkg::RCC_RESULT: begin
        st_nxt = rcc_pkg::RCC_IDLE;
        ev_done = 1'b1;
        ev_valid = got_valid_r;
        result_nxt = '0;
        result_nxt[rcc_pkg::RES_DONE_BIT] = 1'b1;
        result_nxt[rcc_pkg::RES_VALID_BIT] = got_valid_r;
        got_valid_nxt = 1'b0;
        cmd_act_nxt = 1'b0;
      end
      default: st_nxt = rcc_pkg::RCC_IDLE;
    endcase
    if (ev_valid) begin
      vflag_nxt = 1'b1;
      vcnt_nxt = '0;
    end else if (vflag_r) begin
      if (vcnt_r == VALID_M1) begin
        vflag_nxt = 1'b0;
      end else begin
        vcnt_nxt = vcnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= rcc_pkg::RCC_IDLE;
      cnt_r <= '0;
      hcnt_r <= '0;
      vcnt_r <= '0;
      hold_d_r <= 1'b0;
      vflag_r <= 1'b0;
      cmd_r <= '0;
      cmd_pend_r <= 1'b0;
      cmd_act_r <= 1'b0;
      got_valid_r <= 1'b0;
      paused_r <= 1'b0;
      result_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      hcnt_r <= hcnt_nxt;
      vcnt_r <= vcnt_nxt;
      hold_d_r <= hold_d_nxt;
      vflag_r <= vflag_nxt;
      cmd_r <= cmd_nxt;
      cmd_pend_r <= cmd_pend_nxt;
      cmd_act_r <= cmd_act_nxt;
      got_valid_r <= got_valid_nxt;
      paused_r <= paused_nxt;
      result_r <= result_nxt;
    end
  end

  // ==========================================================
  // pin outputs, registered
  logic sync_r, sync_nxt, rf_r, rf_nxt, wla_r, wla_nxt;
  always_comb begin
    rf_nxt = (st_nxt == rcc_pkg::RCC_BURST);
    sync_nxt = (st_nxt == rcc_pkg::RCC_BURST) || (st_nxt == rcc_pkg::RCC_RESULT);
    // command setting wins only while the command runs
    wla_nxt = (cmd_act_nxt && cmd_nxt[rcc_pkg::CMD_SYNC_VALID_BIT]) ? cmd_nxt[rcc_pkg::CMD_SYNC_BIT]
      : wireless_align_in;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= 1'b0;
      rf_r <= 1'b0;
      wla_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      rf_r <= rf_nxt;
      wla_r <= wla_nxt;
    end
  end
  assign sync_out = sync_r;
  assign rf_enable = rf_r;
  assign tx_status_n = !rf_r;
  assign wireless_align_active = wla_r;
  assign valid_read_flag_out = vflag_r;

  // ==========================================================
  // register port and interrupts
  logic [rcc_pkg::IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] txd_r, txd_nxt;
  logic txv_r, txv_nxt;

  assign ui.tx_data = txd_r;
  assign ui.tx_valid = txv_r;
  always_comb begin
    ev = '0;
    ev[rcc_pkg::EV_CYCLE_DONE] = ev_done;
    ev[rcc_pkg::EV_VALID_READ] = ev_valid;
    ev[rcc_pkg::EV_RX_BYTE] = ui.rx_valid;
    ev[rcc_pkg::EV_RX_ERR] = ui.rx_err;
    ist_nxt = ist_r;
    imask_nxt = imask_r;
    txd_nxt = txd_r;
    txv_nxt = txv_r && !ui.tx_ready;
    rdata_nxt = '0;
    if (reg_wr && hit(reg_addr, rcc_pkg::REG_IRQ_STAT)) begin
      ist_nxt = ist_r & ~reg_wdata[rcc_pkg::IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev; // set beats clear
    if (reg_wr && hit(reg_addr, rcc_pkg::REG_IRQ_MASK)) begin
      imask_nxt = reg_wdata[rcc_pkg::IRQ_W-1:0];
    end
    if (reg_wr && hit(reg_addr, rcc_pkg::REG_TX_DATA) && !txv_r) begin
      txd_nxt = reg_wdata[7:0];
      txv_nxt = 1'b1;
    end
    if (reg_rd) begin
      if (hit(reg_addr, rcc_pkg::REG_STATUS)) begin
        rdata_nxt = {24'h00_0000, paused_r, txv_r, cmd_pend_r, cmd_act_r, wla_r, vflag_r, rf_r, sync_r};
      end else if (hit(reg_addr, rcc_pkg::REG_IRQ_STAT)) begin
        rdata_nxt = {28'h000_0000, ist_r};
      end else if (hit(reg_addr, rcc_pkg::REG_IRQ_MASK)) begin
        rdata_nxt = {28'h000_0000, imask_r};
      end else if (hit(reg_addr, rcc_pkg::REG_RX_DATA)) begin
        rdata_nxt = {24'h00_0000, ui.rx_data};
      end else if (hit(reg_addr, rcc_pkg::REG_RESULT)) begin
        rdata_nxt = result_r;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= '0;
      imask_r <= '0;
      rdata_r <= '0;
      txd_r <= '0;
      txv_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
      txd_r <= txd_nxt;
      txv_r <= txv_nxt;
    end
  end
  assign reg_rdata = rdata_r;
  assign irq = |(ist_r & imask_r);
endmodule : rcc_top
`default_nettype wire

// ---- rcc_top_sva.sv ----
// concurrent checks on the pins of the reader cycle control block
`default_nettype none
module rcc_top_sva #(
  parameter int unsigned BURST_CYC = rcc_pkg::BURST_CYC,
  parameter int unsigned VALID_CYC = rcc_pkg::VALID_CYC,
  parameter int unsigned TRIG_CYC = rcc_pkg::TRIG_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic holdoff_trigger_in,
  input wire logic continuous_read_in,
  input wire logic wireless_align_in,
  input wire logic sync_out,
  input wire logic tx_status_n,
  input wire logic valid_read_flag_out,
  input wire logic rf_enable,
  input wire logic wireless_align_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // helper counters: length of each high run so far
  logic [31:0] burst_cnt_r, burst_cnt_nxt, hold_cnt_r, hold_cnt_nxt, valid_cnt_r, valid_cnt_nxt;
  always_comb begin
    burst_cnt_nxt = rf_enable ? burst_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    hold_cnt_nxt = holdoff_trigger_in ? hold_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    valid_cnt_nxt = valid_read_flag_out ? valid_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      burst_cnt_r <= 32'h0000_0000;
      hold_cnt_r <= 32'h0000_0000;
      valid_cnt_r <= 32'h0000_0000;
    end else begin
      burst_cnt_r <= burst_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      valid_cnt_r <= valid_cnt_nxt;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_burst_end;
    $fell(rf_enable);
  endsequence
  sequence s_trig_pulse;
    !sync_out && $fell(holdoff_trigger_in) && hold_cnt_r >= TRIG_CYC;
  endsequence
  property p_stat_inv; tx_status_n != rf_enable; endproperty
  a_stat_inv: assert property (p_stat_inv) else $error("status pin not inverse of transmitter");
  property p_sync_cover; rf_enable |-> sync_out; endproperty
  a_sync_cover: assert property (p_sync_cover) else $error("sync low during burst");
  property p_sync_start; $rose(rf_enable) |-> $rose(sync_out); endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync did not rise with burst");
  property p_sync_end; s_burst_end |=> $fell(sync_out); endproperty
  a_sync_end: assert property (p_sync_end) else $error("sync did not drop after cycle");
  property p_burst_len; s_burst_end |-> burst_cnt_r == BURST_CYC; endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
  property p_holdoff; !sync_out && holdoff_trigger_in |=> !rf_enable; endproperty
  a_holdoff: assert property (p_holdoff) else $error("transmitted while held off");
  property p_no_abort; rf_enable && $rose(holdoff_trigger_in) && burst_cnt_r < BURST_CYC - 1 |=> rf_enable; endproperty
  a_no_abort: assert property (p_no_abort) else $error("burst cut by hold-off");
  property p_trig; s_trig_pulse |=> rf_enable; endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse did not start a read");
  property p_valid_len; $fell(valid_read_flag_out) |-> valid_cnt_r == VALID_CYC; endproperty
  a_valid_len: assert property (p_valid_len) else $error("valid flag length wrong");
  property p_valid_src; $rose(valid_read_flag_out) |-> $fell(sync_out); endproperty
  a_valid_src: assert property (p_valid_src) else $error("valid flag outside cycle end");
  property p_wla; (!sync_out && $stable(wireless_align_in)) [*3] |-> wireless_align_active == wireless_align_in;
  endproperty
  a_wla: assert property (p_wla) else $error("wireless align not following input");
  property p_cont; $fell(sync_out) && continuous_read_in && !holdoff_trigger_in |-> ##[1:3] $rose(sync_out);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode did not restart");
endmodule : rcc_top_sva
bind rcc_top rcc_top_sva #(.BURST_CYC(BURST_CYC), .VALID_CYC(VALID_CYC), .TRIG_CYC(TRIG_CYC)) rcc_top_sva_i (
  .sys_clk(sys_clk), .resetn(resetn), .holdoff_trigger_in(holdoff_trigger_in),
  .continuous_read_in(continuous_read_in), .wireless_align_in(wireless_align_in), .sync_out(sync_out),
  .tx_status_n(tx_status_n), .valid_read_flag_out(valid_read_flag_out), .rf_enable(rf_enable),
  .wireless_align_active(wireless_align_active)
);
`default_nettype wire

// ---- rcc_host_model.sv ----
// serial host model: idle receive line, samples start bit and two data bits of each sent byte
`default_nettype none
module rcc_host_model #(
  parameter int unsigned BIT_CYC = rcc_pkg::BAUD_DIV
) (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd,
  output logic [2:0] frame,
  output logic done
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // full bytes take far longer than the run allows, so only the frame head is checked
  initial begin
    rxd = 1'b1;
    frame = 3'h0;
    done = 1'b0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      frame[0] <= txd;
      repeat (BIT_CYC) @(posedge sys_clk);
      frame[1] <= txd;
      repeat (BIT_CYC) @(posedge sys_clk);
      frame[2] <= txd;
      done <= 1'b1;
    end
  end
endmodule : rcc_host_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the reader cycle control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned B_CYC = 50;
  localparam int unsigned V_CYC = 60;
  typedef struct packed {logic [7:0] len; logic tag; logic start;} rcc_row_t;
  logic sys_clk = 1'b0, resetn = 1'b0, holdoff_trigger_in = 1'b0, continuous_read_in = 1'b0;
  logic wireless_align_in = 1'b0, tag_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rxd;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic txd, sync_out, tx_status_n, valid_read_flag_out, rf_enable, wireless_align_active, irq, host_done;
  logic [2:0] frame;
  int miscompares = 0, checks = 0, n, i;
  rcc_row_t rows [4] = '{'{8'h0a, 1'b1, 1'b1}, '{8'h0e, 1'b0, 1'b1}, '{8'h05, 1'b1, 1'b0}, '{8'h09, 1'b0, 1'b0}};
  always #2 sys_clk = ~sys_clk;
  rcc_top #(.BURST_CYC(B_CYC), .VALID_CYC(V_CYC), .TRIG_CYC(10)) rcc_top_i (.sys_clk(sys_clk), .resetn(resetn),
    .holdoff_trigger_in(holdoff_trigger_in), .continuous_read_in(continuous_read_in),
    .wireless_align_in(wireless_align_in), .rxd(rxd), .txd(txd), .sync_out(sync_out), .tx_status_n(tx_status_n),
    .valid_read_flag_out(valid_read_flag_out), .rf_enable(rf_enable), .wireless_align_active(wireless_align_active),
    .tag_valid(tag_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  rcc_host_model rcc_host_model_i (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .frame(frame), .done(host_done));
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read
  // waits a few cycles for a burst, then counts its high cycles
  task automatic burst_len(output int len);
    int k;
    len = 0;
    #1;
    for (k = 0; k < 8 && rf_enable !== 1'b1; k++) @(posedge sys_clk) #1;
    if (rf_enable === 1'b1) check({30'h0, tx_status_n, sync_out}, 32'h0000_0001);
    while (rf_enable === 1'b1 && len < 200) begin
      len++;
      @(posedge sys_clk) #1;
    end
  endtask : burst_len
  // ==========================================================
  // watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 check({26'h0, txd, tx_status_n, sync_out, rf_enable, valid_read_flag_out, irq}, 32'h0000_0030);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      holdoff_trigger_in <= 1'b1;
      tag_valid <= rows[i].tag;
      repeat (rows[i].len) @(posedge sys_clk);
      holdoff_trigger_in <= 1'b0;
      burst_len(n);
      check(n, rows[i].start ? B_CYC : 0);
      @(posedge sys_clk) #1;
      check({31'h0, valid_read_flag_out}, {31'h0, rows[i].tag & rows[i].start});
      repeat (V_CYC + 2) @(posedge sys_clk);
      #1 check({30'h0, valid_read_flag_out, sync_out}, 32'h0000_0000);
    end
    // hold-off delays the cycle, a mid-burst rise does not cut it
    @(posedge sys_clk);
    tag_valid <= 1'b0;
    holdoff_trigger_in <= 1'b1;
    continuous_read_in <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 check({31'h0, rf_enable}, 32'h0000_0000);
    @(posedge sys_clk);
    holdoff_trigger_in <= 1'b0;
    fork
      burst_len(n);
      begin
        repeat (10) @(posedge sys_clk);
        holdoff_trigger_in <= 1'b1;
      end
    join
    check(n, B_CYC);
    repeat (20) @(posedge sys_clk);
    #1 check({31'h0, rf_enable}, 32'h0000_0000);
    @(posedge sys_clk);
    holdoff_trigger_in <= 1'b0;
    burst_len(n);
    check(n, B_CYC);
    burst_len(n);
    check(n, B_CYC);
    @(posedge sys_clk);
    continuous_read_in <= 1'b0;
    repeat (B_CYC + 20) @(posedge sys_clk);
    #1 check({30'h0, sync_out, rf_enable}, 32'h0000_0000);
    @(posedge sys_clk);
    wireless_align_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 check({31'h0, wireless_align_active}, 32'h0000_0001);
    @(posedge sys_clk);
    wireless_align_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check({31'h0, wireless_align_active}, 32'h0000_0000);
    // interrupt status, mask, clear and an unmapped place
    reg_read(rcc_pkg::REG_IRQ_STAT, d);
    check(d, 32'h0000_0003);
    reg_write(rcc_pkg::REG_IRQ_MASK, 32'h0000_0002);
    @(posedge sys_clk) #1 check({31'h0, irq}, 32'h0000_0001);
    reg_write(rcc_pkg::REG_IRQ_STAT, 32'h0000_0002);
    @(posedge sys_clk) #1 check({31'h0, irq}, 32'h0000_0000);
    reg_read(rcc_pkg::REG_IRQ_STAT, d);
    check(d, 32'h0000_0001);
    reg_read(8'h40, d);
    check(d, 32'h0000_0000);
    reg_read(rcc_pkg::REG_IRQ_MASK, d);
    check(d, 32'h0000_0002);
    // last cycle ran without a transponder: done set, valid clear
    reg_read(rcc_pkg::REG_RESULT, d);
    check(d, 32'h0000_0001);
    // serial byte out: start bit low, then least significant bits first
    reg_write(rcc_pkg::REG_TX_DATA, 32'h0000_00a5);
    // two and a half bit times must pass before the third sample is taken
    for (n = 0; n < 70000 && host_done !== 1'b1; n++) @(posedge sys_clk);
    #1 check({28'h0, host_done, frame}, 32'h0000_000a);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
